/* bench/rss_ref_model.sv */
/*
 * far-side model: the monitored reference inputs and the pair-select pin.
 * assumes the bench sets the masks just after a rising clock edge.
 */
`timescale 1ns/100ps
module rss_ref_model #(
	parameter int STRAP = 20
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // reset, active high
	input wire logic [14:1] ok, // inputs that are valid
	input wire logic [14:1] lost, // valid inputs whose clock stops
	input wire logic strap, // ask for pin-method external mode
	input wire logic pin_lvl, // pin level outside the strap window
	output rss_pkg::rss_src_t src, // monitor results
	output logic pair_select_pin // pair-select pin
);
	int hold;
	always @(posedge clk_sys or posedge rst)
		if (rst)
			hold <= STRAP + 4;
		else if (hold > 0)
			hold <= hold - 1;
	// pin held high through reset and past the strap window
	assign pair_select_pin = (strap && (rst || hold > 0)) ? 1'b1 : pin_lvl;
	assign src = '{valid: ok, activity: ok & ~lost};
endmodule

/* bench/rss_selector_props.sv */
/*
 * assertions on the selector ports.
 * assumes register writes take effect at the edge that takes them.
 */
`timescale 1ns/100ps
module rss_selector_props (
	input wire logic clk_sys, // clock
	input wire logic rst, // reset
	input wire rss_pkg::rss_bus_req_t bus_req, // register request
	input wire rss_pkg::rss_src_t src, // monitor results
	input wire logic pair_select_pin, // pair select
	input wire logic jtag_tdo, // scan data
	input wire logic tdo_out, // scan pin
	input wire logic [3:0] selected_source, // chosen input
	input wire logic [15:0] freerun_trim, // applied trim
	input wire logic freerun_active, // free-run
	input wire logic monitoring_enabled // monitors on
);
	logic [7:0] mon_reg, frc_reg;
	logic frs_reg;
	logic [3:0] held_reg;
	wire loss = mon_reg[5] && monitoring_enabled && selected_source != 4'h0
		&& !src.activity[selected_source];
	wire wr_on = bus_req.wr;
	// shadows of the control registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mon_reg <= rss_pkg::RST_MONITOR_CONFIG;
			frc_reg <= rss_pkg::RST_FORCED_CHOICE;
			frs_reg <= 1'b0;
			held_reg <= 4'h0;
		end else begin
			if (!loss) held_reg <= selected_source;
			if (wr_on && bus_req.addr == rss_pkg::OFS_MONITOR_CONFIG) mon_reg <= bus_req.wdata;
			if (wr_on && bus_req.addr == rss_pkg::OFS_FORCED_CHOICE) frc_reg <= bus_req.wdata;
			if (wr_on && bus_req.addr == rss_pkg::OFS_CONTROL_MODE) frs_reg <= bus_req.wdata[1];
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_pin_steady;
		mon_reg[4] ##1 (mon_reg[4] && $stable(pair_select_pin));
	endsequence
	sequence s_forced;
		frc_reg[3:0] != 4'h0 && frc_reg[3:0] != 4'hF && monitoring_enabled;
	endsequence
	a_forced_pick: assert property (s_forced ##1 (s_forced and $stable(frc_reg))
		|-> selected_source == frc_reg[3:0]) else $error("forced input not taken");
	a_tdo_pass: assert property (!mon_reg[6] |-> tdo_out == jtag_tdo)
		else $error("scan pin not passed through");
	a_loss_flag: assert property (loss && mon_reg[6] |-> ##[1:4] tdo_out)
		else $error("loss not flagged");
	a_loss_switch: assert property (loss |-> ##[1:4] selected_source != held_reg)
		else $error("no switch on loss");
	a_tdo_hold: assert property (mon_reg[6] && tdo_out && !wr_on |=> tdo_out)
		else $error("flag dropped without clear");
	a_ext_pick: assert property (s_pin_steady |-> (pair_select_pin ?
		selected_source inside {4'h3, 4'h5} : selected_source inside {4'h4, 4'h6}))
		else $error("wrong pair input");
	a_ext_monitor: assert property (mon_reg[4] |-> !monitoring_enabled)
		else $error("monitors on in external mode");
	a_free_exit: assert property (freerun_active && selected_source != 4'h0 && !frs_reg
		&& monitoring_enabled |-> ##[1:3] !freerun_active) else $error("stuck in free-run");
	a_trim_low: assert property (wr_on && bus_req.addr == rss_pkg::OFS_TRIM_LOW
		|=> freerun_trim[7:0] == $past(bus_req.wdata)) else $error("trim not applied");
endmodule
bind rss_selector rss_selector_props u_props (.clk_sys(clk_sys), .rst(rst),
	.bus_req(bus_req), .src(src), .pair_select_pin(pair_select_pin), .jtag_tdo(jtag_tdo),
	.tdo_out(tdo_out), .selected_source(selected_source), .freerun_trim(freerun_trim),
	.freerun_active(freerun_active), .monitoring_enabled(monitoring_enabled));

/* bench/tb_top.sv */
/*
 * self-checking bench for the reference source selector.
 * assumes the package, design, far-side model and checker are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
	logic clk_sys = 0, rst = 1, phase_locked = 0, jtag_tdo = 0, strap = 0, pin_lvl = 0;
	logic [14:1] ok = '0, lost = '0;
	logic [2:0] fsc = 3'h0;
	rss_pkg::rss_bus_req_t bus_req = '0;
	rss_pkg::rss_src_t src;
	logic [7:0] bus_rdata;
	logic [3:0] sel;
	logic [15:0] trim;
	logic pin, tdo_out, free, mon_on;
	int errors = 0, num_checks = 0, cycles = 0;
	rss_selector #(.STRAP_CYC(20), .LOCK_WAIT_CYC(100), .LOCK_QUAL_CYC(10),
		.PHASE_LOST_CYC(100)) dut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .src(src), .phase_locked(phase_locked),
		.pair_select_pin(pin), .forced_state_cmd(fsc), .jtag_tdo(jtag_tdo),
		.tdo_out(tdo_out), .selected_source(sel), .freerun_trim(trim),
		.freerun_active(free), .monitoring_enabled(mon_on));
	rss_ref_model #(.STRAP(20)) far (.clk_sys(clk_sys), .rst(rst), .ok(ok), .lost(lost),
		.strap(strap), .pin_lvl(pin_lvl), .src(src), .pair_select_pin(pin));
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		jtag_tdo <= ~jtag_tdo;
		if (cycles == 4000) begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want) begin
			errors++;
			$display("BAD %0t saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		tick(1);
		bus_req = '0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		tick(1);
		check(bus_rdata, want);
		bus_req = '0;
		tick(1);
	endtask
	task automatic t_reset;
		rd(rss_pkg::OFS_FORCED_CHOICE, rss_pkg::RST_FORCED_CHOICE);
		rd(rss_pkg::OFS_MONITOR_CONFIG, 8'h00);
		rd(8'h7F, 8'h00);
		wr(rss_pkg::OFS_OPERATING_STATE, 8'hFF);
		rd(rss_pkg::OFS_OPERATING_STATE, {5'h00, rss_pkg::CODE_FREE_RUN});
		check(free, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_prio;
		wr(rss_pkg::OFS_PRIORITY_BASE, 8'h23);
		wr(rss_pkg::OFS_PRIORITY_BASE + 8'h01, 8'h01);
		ok = 14'h000B;
		phase_locked = 1'b1;
		tick(3);
		check(sel, 4'h2);
		check(free, 1'b0);
		rd(rss_pkg::OFS_OPERATING_STATE, {5'h00, rss_pkg::CODE_PRE_LOCKED});
		tick(15);
		rd(rss_pkg::OFS_OPERATING_STATE, {5'h00, rss_pkg::CODE_LOCKED});
		ok[2] = 1'b0;
		tick(3);
		check(sel, 4'h1);
		ok[2] = 1'b1;
		tick(5);
		check(sel, 4'h1);
		wr(rss_pkg::OFS_CONTROL_MODE, 8'h01);
		tick(3);
		check(sel, 4'h2);
		wr(rss_pkg::OFS_CONTROL_MODE, 8'h00);
		$display("test priority done");
	endtask
	task automatic t_fifo;
		wr(rss_pkg::OFS_PRIORITY_BASE, 8'h00);
		wr(rss_pkg::OFS_PRIORITY_BASE + 8'h02, 8'h44);
		ok = 14'h0020;
		tick(3);
		ok[5] = 1'b1;
		tick(3);
		check(sel, 4'h6);
		ok[6] = 1'b0;
		tick(3);
		check(sel, 4'h5);
		wr(rss_pkg::OFS_CONTROL_MODE, 8'h01);
		ok[6] = 1'b1;
		tick(4);
		check(sel, 4'h5);
		wr(rss_pkg::OFS_CONTROL_MODE, 8'h00);
		ok[7] = 1'b1;
		wr(rss_pkg::OFS_FORCED_CHOICE, 8'h07);
		tick(3);
		check(sel, 4'h7);
		wr(rss_pkg::OFS_FORCED_CHOICE, 8'h00);
		tick(3);
		check(sel, 4'h5);
		wr(rss_pkg::OFS_FORCED_CHOICE, 8'h0F);
		$display("test fifo done");
	endtask
	task automatic t_ultra;
		wr(rss_pkg::OFS_MONITOR_CONFIG, 8'h60);
		lost[5] = 1'b1;
		tick(4);
		check(tdo_out, 1'b1);
		check(sel, 4'h6);
		rd(rss_pkg::OFS_INTERRUPT_FLAGS, 8'h40);
		lost[5] = 1'b0;
		tick(4);
		check(tdo_out, 1'b1);
		wr(rss_pkg::OFS_INTERRUPT_FLAGS, 8'h40);
		check(tdo_out, 1'b0);
		wr(rss_pkg::OFS_MONITOR_CONFIG, 8'h00);
		$display("test ultra done");
	endtask
	task automatic t_ext;
		wr(rss_pkg::OFS_PRIORITY_BASE + 8'h01, 8'h01);
		wr(rss_pkg::OFS_MONITOR_CONFIG, 8'h10);
		pin_lvl = 1'b1;
		tick(3);
		check(sel, 4'h3);
		check(mon_on, 1'b0);
		pin_lvl = 1'b0;
		tick(3);
		check(sel, 4'h6);
		rd(rss_pkg::OFS_OPERATING_STATE, {5'h00, rss_pkg::CODE_LOCKED});
		wr(rss_pkg::OFS_MONITOR_CONFIG, 8'h00);
		wr(rss_pkg::OFS_TRIM_LOW, 8'hA5);
		wr(rss_pkg::OFS_TRIM_HIGH, 8'h3C);
		check(trim, 16'h3CA5);
		$display("test external done");
	endtask
	task automatic t_phase;
		fsc = rss_pkg::CODE_FREE_RUN;
		wr(rss_pkg::OFS_CONTROL_MODE, 8'h02);
		check(free, 1'b1);
		fsc = rss_pkg::CODE_LOCKED;
		tick(1);
		check(free, 1'b0);
		wr(rss_pkg::OFS_CONTROL_MODE, 8'h00);
		phase_locked = 1'b0;
		tick(3);
		rd(rss_pkg::OFS_OPERATING_STATE, {5'h00, rss_pkg::CODE_LOST_PHASE});
		tick(100);
		rd(rss_pkg::OFS_OPERATING_STATE, {5'h00, rss_pkg::CODE_PRE_LOCKED2});
		check(sel, 4'h5);
		phase_locked = 1'b1;
		tick(12);
		rd(rss_pkg::OFS_OPERATING_STATE, {5'h00, rss_pkg::CODE_LOCKED});
		$display("test phase done");
	endtask
	task automatic t_strap;
		strap = 1'b1;
		pin_lvl = 1'b1;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(30);
		rd(rss_pkg::OFS_PAIR_A_TOL, rss_pkg::TOL_WIDE);
		check(mon_on, 1'b0);
		wr(rss_pkg::OFS_PAIR_A_TOL, 8'h00);
		rd(rss_pkg::OFS_PAIR_A_TOL, 8'h00);
		$display("test strap done");
	endtask
	initial begin
		tick(12);
		rst = 1'b0;
		tick(2);
		t_reset();
		t_prio();
		t_fifo();
		t_ultra();
		t_ext();
		t_phase();
		t_strap();
		complete_run();
	end
endmodule

/* core/rss_pkg.sv */
/*
 * package for the reference source selector: register offsets, field
 * positions, reset values, timing counts, states and bus carrier types.
 * assumes a 25 MHz system clock and an 8-bit microprocessor register port.
 */
package rss_pkg;
	localparam int unsigned N_INPUTS = 14;
	localparam logic [7:0] OFS_INTERRUPT_FLAGS = 8'h06;
	localparam logic [7:0] OFS_OPERATING_STATE = 8'h09;
	localparam logic [7:0] OFS_FORCED_CHOICE = 8'h33;
	localparam logic [7:0] OFS_TRIM_LOW = 8'h3C;
	localparam logic [7:0] OFS_TRIM_HIGH = 8'h3D;
	localparam logic [7:0] OFS_PAIR_A_TOL = 8'h41;
	localparam logic [7:0] OFS_PAIR_B_TOL = 8'h42;
	localparam logic [7:0] OFS_MONITOR_CONFIG = 8'h48;
	localparam logic [7:0] OFS_PRIORITY_BASE = 8'h18;
	localparam logic [7:0] OFS_CONTROL_MODE = 8'h34;
	localparam int unsigned PRIORITY_REGS = 7;
	localparam int unsigned BIT_MAIN_REF_FAILED = 6;
	localparam int unsigned BIT_ULTRA_FAST = 5;
	localparam int unsigned BIT_LOSS_ON_SCAN = 6;
	localparam int unsigned BIT_EXT_SWITCH = 4;
	localparam int unsigned BIT_REVERTIVE = 0;
	localparam int unsigned BIT_FORCED_STATE = 1;
	localparam logic [7:0] RST_FORCED_CHOICE = 8'h0F;
	localparam logic [7:0] RST_MONITOR_CONFIG = 8'h00;
	localparam logic [7:0] RST_CONTROL_MODE = 8'h00;
	localparam logic [7:0] RST_PRIORITY = 8'h00;
	localparam logic [7:0] TOL_NORMAL = 8'h00;
	localparam logic [7:0] TOL_WIDE = 8'h01;
	localparam logic [7:0] RST_TRIM = 8'h00;
	localparam longint unsigned CLK_HZ = 25000000;
	localparam longint unsigned STRAP_HOLD_MS = 251;
	localparam longint unsigned LOCK_WAIT_S = 100;
	localparam longint unsigned LOCK_QUAL_S = 1;
	localparam longint unsigned PHASE_LOST_S = 100;
	localparam longint unsigned STRAP_CYCLES = (STRAP_HOLD_MS * CLK_HZ + 999) / 1000;
	localparam longint unsigned LOCK_WAIT_CYCLES = LOCK_WAIT_S * CLK_HZ;
	localparam longint unsigned LOCK_QUAL_CYCLES = LOCK_QUAL_S * CLK_HZ;
	localparam longint unsigned PHASE_LOST_CYCLES = PHASE_LOST_S * CLK_HZ;
	localparam logic [2:0] CODE_FREE_RUN = 3'h1;
	localparam logic [2:0] CODE_HOLDOVER = 3'h2;
	localparam logic [2:0] CODE_LOCKED = 3'h4;
	localparam logic [2:0] CODE_PRE_LOCKED2 = 3'h5;
	localparam logic [2:0] CODE_PRE_LOCKED = 3'h6;
	localparam logic [2:0] CODE_LOST_PHASE = 3'h7;
	localparam logic [3:0] NO_SOURCE = 4'h0;

	typedef enum logic [2:0] {
		ST_FREE_RUN,
		ST_PRE_LOCKED,
		ST_LOCKED,
		ST_LOST_PHASE,
		ST_PRE_LOCKED2,
		ST_HOLDOVER
	} rss_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rss_bus_req_t;

	typedef struct packed {
		logic [N_INPUTS:1] valid;
		logic [N_INPUTS:1] activity;
	} rss_src_t;
endpackage

/* core/rss_selector.sv */
/*
 * reference source selector and operating-state controller.
 * assumes input validity and activity come from the monitors, synchronous to
 * clk_sys; the pair-select strap is sampled after reset release.
 */
// How it works
// RL1: non-revertive keeps the current valid source despite better ones
// RL2: a failed current source always causes a switch
// RL3: forced field 0 or 15 means automatic, otherwise forces that input
// RL4: forced field resets to all ones
// RL5: four-bit priority per input, two per byte in seven registers
// RL6: smallest nonzero priority among valid sources wins
// RL7: priority zero excludes the input
// RL8: equal priorities are ordered by validation time; recovery joins the tail
// RL9: revertive setting does not order equal priorities; the lower channel wins only a validation-time tie
// RL10: ultra-fast mode flags loss of activity and switches source
// RL11: scan-output mirror of the main-reference-failed flag, off by default
// RL12: mirror stays high until software clears the flag
// RL13: external switch mode via control bit or strap held 251 ms
// RL14: pair-select high picks input 3 or 5, low picks 4 or 6
// RL15: strap-enabled mode sets wide tolerance default on inputs 3 to 6
// RL16: input 5 or 6 replaces 3 or 4 when that priority is zero
// RL17: external mode disables monitoring and reports locked
// RL18: automatic state control after reset, forced control by setting
// RL19: free-run follows oscillator, offset by software trim value
// RL20: free-run goes to pre-locked once a source is selected
// RL21: no lock in 100 s returns to free-run and picks another source
// RL22: locked entered from pre-locked states or lost-phase on lock
// RL23: revertive mode moves to a newly valid higher-priority source
// RL24: writing ones to the flag register clears; mirror ignores masks
// RL25: lock counts only after one second of continuous phase lock
// RL26: over 100 s lost-phase disqualifies, to pre-locked2 or holdover
`timescale 1ns/100ps
module rss_selector #(
	parameter longint unsigned STRAP_CYC = rss_pkg::STRAP_CYCLES,
	parameter longint unsigned LOCK_WAIT_CYC = rss_pkg::LOCK_WAIT_CYCLES,
	parameter longint unsigned LOCK_QUAL_CYC = rss_pkg::LOCK_QUAL_CYCLES,
	parameter longint unsigned PHASE_LOST_CYC = rss_pkg::PHASE_LOST_CYCLES
) (
	input wire logic clk_sys, // system clock, 25 MHz
	input wire logic rst, // asynchronous reset, active high
	input wire rss_pkg::rss_bus_req_t bus_req, // register port request
	output logic [7:0] bus_rdata, // register read data
	input wire rss_pkg::rss_src_t src, // monitor validity and activity
	input wire logic phase_locked, // loop phase lock detector
	input wire logic pair_select_pin, // external pair select / strap
	input wire logic [2:0] forced_state_cmd, // state code under forced control
	input wire logic jtag_tdo, // scan chain output when not mirroring
	output logic tdo_out, // scan output pin
	output logic [3:0] selected_source, // selected input, 0 for none
	output logic [15:0] freerun_trim, // trim applied in free-run
	output logic freerun_active, // outputs derive from oscillator
	output logic monitoring_enabled // clock monitors active
);
	// local aliases of the package state type and labels
	typedef rss_pkg::rss_state_t rss_state_t;
	localparam rss_state_t ST_FREE_RUN = rss_pkg::ST_FREE_RUN;
	localparam rss_state_t ST_PRE_LOCKED = rss_pkg::ST_PRE_LOCKED;
	localparam rss_state_t ST_LOCKED = rss_pkg::ST_LOCKED;
	localparam rss_state_t ST_LOST_PHASE = rss_pkg::ST_LOST_PHASE;
	localparam rss_state_t ST_PRE_LOCKED2 = rss_pkg::ST_PRE_LOCKED2;
	localparam rss_state_t ST_HOLDOVER = rss_pkg::ST_HOLDOVER;

	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] forced;
		logic [15:0] trim;
		logic [7:0] tol_a;
		logic [7:0] tol_b;
		logic [7:0] mon_cfg;
		logic [7:0] ctl_mode;
		logic [rss_pkg::PRIORITY_REGS*8-1:0] prio;
		logic [rss_pkg::N_INPUTS:1] valid_d;
		logic [rss_pkg::N_INPUTS*8-1:0] stamp;
		logic [7:0] seq;
		logic [3:0] cur;
		logic [3:0] excluded;
		rss_state_t st;
		logic [31:0] timer;
		logic [31:0] qual;
		logic [31:0] strap_cnt;
		logic strap_busy;
		logic strap_mode;
		logic [7:0] rdata;
	} rss_core_t;

	rss_core_t s_reg, s_next;

	function automatic logic [3:0] prio_of(input logic [rss_pkg::PRIORITY_REGS*8-1:0] p,
			input int unsigned n);
		prio_of = p[(n-1)*4 +: 4]; // RL5
	endfunction

	function automatic logic better(input logic [3:0] pa, input logic [7:0] sa,
			input logic [3:0] pb, input logic [7:0] sb, input logic [7:0] seq);
		logic [7:0] aa;
		logic [7:0] ab;
		aa = seq - sa;
		ab = seq - sb;
		better = (pa < pb) || ((pa == pb) && (aa > ab)); // RL6 RL8 RL9
	endfunction

	logic [3:0] best;
	logic [3:0] best_p;
	logic [7:0] best_s;
	logic auto_sel;
	logic ext_mode;
	logic [3:0] ext_src;
	logic cur_ok;
	logic [3:0] pn;
	logic loss;

	always_comb begin
		best = rss_pkg::NO_SOURCE;
		best_p = 4'hF;
		best_s = 8'h00;
		pn = 4'h0;
		for (int unsigned n = 1; n <= rss_pkg::N_INPUTS; n++) begin
			pn = prio_of(s_reg.prio, n);
			// an input without activity is no candidate under ultra-fast switching
			if (src.valid[n] && (src.activity[n] || !s_reg.mon_cfg[rss_pkg::BIT_ULTRA_FAST]) // RL10
					&& pn != 4'h0 && n != s_reg.excluded // RL7
					&& (best == rss_pkg::NO_SOURCE
					|| better(pn, s_reg.stamp[(n-1)*8 +: 8], best_p, best_s, s_reg.seq))) begin
				best = 4'(n);
				best_p = pn;
				best_s = s_reg.stamp[(n-1)*8 +: 8];
			end
		end
	end

	always_comb begin
		s_next = s_reg;
		auto_sel = s_reg.forced[3:0] == 4'h0 || s_reg.forced[3:0] == 4'hF; // RL3
		ext_mode = s_reg.mon_cfg[rss_pkg::BIT_EXT_SWITCH] || s_reg.strap_mode; // RL13
		if (pair_select_pin) begin // RL14
			ext_src = (prio_of(s_reg.prio, 3) == 4'h0) ? 4'h5 : 4'h3; // RL16
		end else begin
			ext_src = (prio_of(s_reg.prio, 4) == 4'h0) ? 4'h6 : 4'h4; // RL16
		end
		cur_ok = s_reg.cur != rss_pkg::NO_SOURCE && src.valid[s_reg.cur]
			&& prio_of(s_reg.prio, s_reg.cur) != 4'h0; // RL7
		loss = s_reg.mon_cfg[rss_pkg::BIT_ULTRA_FAST] && s_reg.cur != rss_pkg::NO_SOURCE
			&& !src.activity[s_reg.cur] && !ext_mode; // RL10
		// stamps track order of validation; a recovering source joins the tail
		for (int unsigned n = 1; n <= rss_pkg::N_INPUTS; n++) begin
			if (src.valid[n] && !s_reg.valid_d[n]) begin
				s_next.stamp[(n-1)*8 +: 8] = s_reg.seq; // RL8
			end
		end
		s_next.valid_d = src.valid;
		if (src.valid != s_reg.valid_d) begin
			s_next.seq = s_reg.seq + 8'h01;
		end
		// source choice
		if (ext_mode) begin
			s_next.cur = ext_src; // RL17
		end else if (!auto_sel) begin
			s_next.cur = s_reg.forced[3:0]; // RL3
		end else if (!cur_ok || loss) begin
			s_next.cur = (best == s_reg.cur) ? rss_pkg::NO_SOURCE : best; // RL2 RL10
		end else if (s_reg.ctl_mode[rss_pkg::BIT_REVERTIVE] && best != rss_pkg::NO_SOURCE
				&& prio_of(s_reg.prio, best) < prio_of(s_reg.prio, s_reg.cur)) begin
			s_next.cur = best; // RL23
		end else begin
			s_next.cur = s_reg.cur; // RL1
		end
		// lock qualification
		if (phase_locked && !ext_mode) begin
			s_next.qual = (s_reg.qual < 32'(LOCK_QUAL_CYC)) ? s_reg.qual + 32'h1 : s_reg.qual;
		end else begin
			s_next.qual = 32'h0;
		end
		// operating state, automatic control
		s_next.timer = s_reg.timer + 32'h1;
		case (s_reg.st)
			ST_FREE_RUN: begin
				s_next.timer = 32'h0;
				if (s_reg.cur != rss_pkg::NO_SOURCE) begin
					s_next.st = ST_PRE_LOCKED; // RL20
				end
			end
			ST_PRE_LOCKED, ST_PRE_LOCKED2: begin
				if (s_reg.qual >= 32'(LOCK_QUAL_CYC) && s_reg.cur != rss_pkg::NO_SOURCE) begin
					s_next.st = ST_LOCKED; // RL22 RL25
				end else if (s_reg.timer >= 32'(LOCK_WAIT_CYC) - 32'h1) begin
					s_next.st = ST_FREE_RUN; // RL21
					s_next.excluded = s_reg.cur;
					s_next.cur = rss_pkg::NO_SOURCE;
				end
			end
			ST_LOCKED: begin
				s_next.timer = 32'h0;
				if (s_reg.cur == rss_pkg::NO_SOURCE) begin
					s_next.st = ST_HOLDOVER;
				end else if (!phase_locked) begin
					s_next.st = ST_LOST_PHASE;
				end
			end
			ST_LOST_PHASE: begin
				if (s_reg.qual >= 32'(LOCK_QUAL_CYC)) begin
					s_next.st = ST_LOCKED; // RL22
				end else if (s_reg.timer >= 32'(PHASE_LOST_CYC)) begin
					s_next.excluded = s_reg.cur; // RL26
					s_next.cur = rss_pkg::NO_SOURCE;
					s_next.timer = 32'h0;
					s_next.st = (best != rss_pkg::NO_SOURCE && best != s_reg.cur)
						? ST_PRE_LOCKED2 : ST_HOLDOVER; // RL26
				end
			end
			ST_HOLDOVER: begin
				s_next.timer = 32'h0;
				if (s_reg.cur != rss_pkg::NO_SOURCE) begin
					s_next.st = ST_PRE_LOCKED2;
				end
			end
			default: begin
				s_next.st = ST_FREE_RUN;
			end
		endcase
		if (ext_mode) begin
			s_next.st = ST_LOCKED; // RL17
		end
		// strap: held high through reset and the hold window
		if (s_reg.strap_busy) begin
			if (!pair_select_pin) begin
				s_next.strap_busy = 1'b0;
			end else if (s_reg.strap_cnt >= 32'(STRAP_CYC) - 32'h1) begin
				s_next.strap_busy = 1'b0;
				s_next.strap_mode = 1'b1; // RL13
				s_next.tol_a = rss_pkg::TOL_WIDE; // RL15
				s_next.tol_b = rss_pkg::TOL_WIDE; // RL15
			end else begin
				s_next.strap_cnt = s_reg.strap_cnt + 32'h1;
			end
		end
		// register port
		s_next.rdata = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				rss_pkg::OFS_INTERRUPT_FLAGS: s_next.rdata = s_reg.flags;
				rss_pkg::OFS_OPERATING_STATE: s_next.rdata = {5'h00, state_code(s_reg.st)};
				rss_pkg::OFS_FORCED_CHOICE: s_next.rdata = s_reg.forced;
				rss_pkg::OFS_CONTROL_MODE: s_next.rdata = s_reg.ctl_mode;
				rss_pkg::OFS_TRIM_LOW: s_next.rdata = s_reg.trim[7:0];
				rss_pkg::OFS_TRIM_HIGH: s_next.rdata = s_reg.trim[15:8];
				rss_pkg::OFS_PAIR_A_TOL: s_next.rdata = s_reg.tol_a;
				rss_pkg::OFS_PAIR_B_TOL: s_next.rdata = s_reg.tol_b;
				rss_pkg::OFS_MONITOR_CONFIG: s_next.rdata = s_reg.mon_cfg;
				default: begin
					for (int unsigned r = 0; r < rss_pkg::PRIORITY_REGS; r++) begin
						if (bus_req.addr == rss_pkg::OFS_PRIORITY_BASE + 8'(r)) begin
							s_next.rdata = s_reg.prio[r*8 +: 8];
						end
					end
				end
			endcase
		end
		if (bus_req.wr) begin
			case (bus_req.addr)
				rss_pkg::OFS_INTERRUPT_FLAGS: s_next.flags = s_reg.flags & ~bus_req.wdata; // RL24
				rss_pkg::OFS_FORCED_CHOICE: s_next.forced = bus_req.wdata;
				rss_pkg::OFS_CONTROL_MODE: s_next.ctl_mode = bus_req.wdata;
				rss_pkg::OFS_TRIM_LOW: s_next.trim[7:0] = bus_req.wdata; // RL19
				rss_pkg::OFS_TRIM_HIGH: s_next.trim[15:8] = bus_req.wdata; // RL19
				rss_pkg::OFS_PAIR_A_TOL: s_next.tol_a = bus_req.wdata; // RL15
				rss_pkg::OFS_PAIR_B_TOL: s_next.tol_b = bus_req.wdata; // RL15
				rss_pkg::OFS_MONITOR_CONFIG: s_next.mon_cfg = bus_req.wdata;
				default: begin
					for (int unsigned r = 0; r < rss_pkg::PRIORITY_REGS; r++) begin
						if (bus_req.addr == rss_pkg::OFS_PRIORITY_BASE + 8'(r)) begin
							s_next.prio[r*8 +: 8] = bus_req.wdata;
						end
					end
				end
			endcase
		end
		// set wins over a simultaneous clear
		if (loss) begin
			s_next.flags[rss_pkg::BIT_MAIN_REF_FAILED] = 1'b1; // RL10
		end
	end

	function automatic logic [2:0] state_code(input rss_state_t st);
		case (st)
			ST_FREE_RUN: state_code = rss_pkg::CODE_FREE_RUN;
			ST_PRE_LOCKED: state_code = rss_pkg::CODE_PRE_LOCKED;
			ST_LOCKED: state_code = rss_pkg::CODE_LOCKED;
			ST_LOST_PHASE: state_code = rss_pkg::CODE_LOST_PHASE;
			ST_PRE_LOCKED2: state_code = rss_pkg::CODE_PRE_LOCKED2;
			ST_HOLDOVER: state_code = rss_pkg::CODE_HOLDOVER;
			default: state_code = rss_pkg::CODE_FREE_RUN;
		endcase
	endfunction

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.forced <= rss_pkg::RST_FORCED_CHOICE; // RL4
			s_reg.mon_cfg <= rss_pkg::RST_MONITOR_CONFIG; // RL11
			s_reg.ctl_mode <= rss_pkg::RST_CONTROL_MODE; // RL18
			s_reg.trim <= {rss_pkg::RST_TRIM, rss_pkg::RST_TRIM};
			s_reg.tol_a <= rss_pkg::TOL_NORMAL;
			s_reg.tol_b <= rss_pkg::TOL_NORMAL;
			s_reg.st <= ST_FREE_RUN;
			s_reg.strap_busy <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	logic [2:0] code_now;
	assign code_now = state_code(s_reg.st);
	// under forced control freerun_active follows the external command; the state register still reads the internal state
	assign freerun_active = s_reg.ctl_mode[rss_pkg::BIT_FORCED_STATE]
		? (forced_state_cmd == rss_pkg::CODE_FREE_RUN) : (code_now == rss_pkg::CODE_FREE_RUN); // RL18
	assign freerun_trim = s_reg.trim; // RL19
	assign selected_source = s_reg.cur;
	assign bus_rdata = s_reg.rdata;
	assign monitoring_enabled = !(s_reg.mon_cfg[rss_pkg::BIT_EXT_SWITCH] || s_reg.strap_mode); // RL17
	assign tdo_out = s_reg.mon_cfg[rss_pkg::BIT_LOSS_ON_SCAN]
		? s_reg.flags[rss_pkg::BIT_MAIN_REF_FAILED] : jtag_tdo; // RL11 RL12 RL24
endmodule
